// ==== sta_pkg.sv ====
package sta_pkg;

   // ----------------------------------------------------------------
   // bus protocol constants
   // ----------------------------------------------------------------
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_ALERT_MASK = 8'hd8;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int MASK_W = 16;
   localparam logic [15:0] MASK_RST = 16'h0000;

   // ----------------------------------------------------------------
   // strap decode map
   // ----------------------------------------------------------------
   localparam int STRAP_PINS = 3;
   localparam int STRAP_COMBOS = 27;
   localparam logic [4:0] LVL_WEIGHT_B = 5'h03;
   localparam logic [4:0] LVL_WEIGHT_C = 5'h09;
   localparam logic [4:0] GRP_B_IDX = 5'h08;
   localparam logic [4:0] GRP_C_IDX = 5'h10;
   localparam logic [6:0] ADDR_BASE_A = 7'h40;
   localparam logic [6:0] ADDR_BASE_B = 7'h10;
   localparam logic [6:0] ADDR_BASE_C = 7'h50;
   localparam logic [6:0] ADDR_LAST_A = 7'h47;
   localparam logic [6:0] ADDR_LAST_B = 7'h17;
   localparam logic [6:0] ADDR_LAST_C = 7'h5a;
   localparam logic [4:0] STRAP_SETTLE_CYC = 5'h10;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 125000;
   localparam int TMO_MS = 25;
   localparam int TMO_MAX_MS = 35;
   localparam int STRETCH_MS = 25;
   localparam int TMO_CYC = TMO_MS * CLK_KHZ;
   localparam int TMO_MAX_CYC = TMO_MAX_MS * CLK_KHZ;
   localparam int STRETCH_CYC = STRETCH_MS * CLK_KHZ;
   localparam int CNT_W = 23;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {LVL_OPEN, LVL_LOW, LVL_HIGH} sta_lvl_t;
   typedef struct packed {logic hi; logic lo;} sta_strap_t;
   typedef struct packed {logic scl; logic sda;} sta_bus_t;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} sta_st_t;
   typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} sta_kind_t;

   typedef struct packed {
      sta_bus_t bus_s1;
      sta_bus_t bus_s2;
      sta_bus_t bus_q;
      sta_strap_t [STRAP_PINS-1:0] strap_s1;
      sta_strap_t [STRAP_PINS-1:0] strap_s2;
      logic [4:0] settle;
      logic addr_ok;
      logic [6:0] addr;
      sta_st_t st;
      sta_kind_t kind;
      logic [3:0] bitcnt;
      logic [7:0] sh;
      logic [7:0] cmd;
      logic wr_hi;
      logic rd_hi;
      logic ara;
      logic more;
      logic sda_drv;
      logic scl_drv;
      logic alert_drv;
      logic [MASK_W-1:0] mask;
      logic [MASK_W-1:0] auto_mask;
      logic [CNT_W-1:0] low_cnt;
      logic [CNT_W-1:0] stretch_cnt;
   } sta_regs_t;

endpackage

// ==== sta_strap_dec.sv ====
module sta_strap_dec (
   input sta_pkg::sta_strap_t [sta_pkg::STRAP_PINS-1:0] strap,
   output logic [6:0] addr
);
   import sta_pkg::*;

   sta_lvl_t [STRAP_PINS-1:0] lvl;
   logic [4:0] idx;

   // ----------------------------------------------------------------
   // three-level sense per pin
   // ----------------------------------------------------------------
   for (genvar i = 0; i < STRAP_PINS; i++)
   begin : g_lvl
      assign lvl[i] = (strap[i].hi && !strap[i].lo) ? LVL_HIGH :
                      (strap[i].lo && !strap[i].hi) ? LVL_LOW : LVL_OPEN;
   end

   // ----------------------------------------------------------------
   // combination index to address
   // ----------------------------------------------------------------
   always_comb
   begin
      idx = 5'(lvl[2]) * LVL_WEIGHT_C + 5'(lvl[1]) * LVL_WEIGHT_B + 5'(lvl[0]);
      if (idx < GRP_B_IDX)
         addr = ADDR_BASE_A + 7'(idx);
      else if (idx < GRP_C_IDX)
         addr = ADDR_BASE_B + 7'(idx - GRP_B_IDX);
      else
         addr = ADDR_BASE_C + 7'(idx - GRP_C_IDX);
   end

endmodule // sta_strap_dec

// ==== sta_target.sv ====
// Function
// - Each of three strap pins is read as high, low or open, giving 27 address choices.
// - Strap combinations map in order from all-open at 40h through 10h-17h and 50h-5Ah.
// - A transfer is timed out when the clock line stays low longer than 25 ms.
// - After a clock-low timeout the interface is reset within 35 ms of the clock going low.
// - Own clock stretching per message stays within 25 ms, else both lines are released.
// - The alert output is gated by the software mask register and by the automatic mask.
// - The automatic mask is set only by winning an alert response address read.
// - The alert response byte carries the lowest alerting address, found by arbitration.
// - The read counts as won only when the whole own address went out; a loss keeps the alert.
// - After winning the alert response read the alert output is released.
// - Winning the read sets the automatic mask for every fault present at that moment.
// - An automatically masked fault raises no new alert until the clear-faults command clears the automatic mask.
module sta_target #(
   parameter int TMO_CYC = sta_pkg::TMO_CYC,
   parameter int STRETCH_CYC = sta_pkg::STRETCH_CYC
) (
   input wire mclk,
   input wire sys_rst,
   input wire scl_i,
   input wire sda_i,
   input sta_pkg::sta_strap_t addr_strap_a,
   input sta_pkg::sta_strap_t addr_strap_b,
   input sta_pkg::sta_strap_t addr_strap_c,
   input wire [sta_pkg::MASK_W-1:0] fault_in,
   input wire hold_req,
   output logic scl_o,
   output logic scl_oe_n,
   output logic sda_o,
   output logic sda_oe_n,
   output logic alert_o,
   output logic alert_oe_n,
   output logic [6:0] own_addr,
   output logic own_addr_vld,
   output logic [sta_pkg::MASK_W-1:0] auto_alert_suppress
);
   import sta_pkg::*;

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (TMO_CYC < 1 || TMO_CYC > TMO_MAX_CYC || TMO_CYC >= 2 ** CNT_W)
   begin : g_bad_tmo
      $error("timeout count out of range");
   end
   if (STRETCH_CYC < 1 || STRETCH_CYC >= 2 ** CNT_W)
   begin : g_bad_str
      $error("stretch budget out of range");
   end

   localparam logic [CNT_W-1:0] TMO_CNT = CNT_W'(TMO_CYC);
   localparam logic [CNT_W-1:0] STR_CNT = CNT_W'(STRETCH_CYC);

   sta_regs_t r;
   sta_regs_t n;
   sta_bus_t bus_in;
   sta_strap_t [STRAP_PINS-1:0] strap_in;
   logic [6:0] dec_addr;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic pending;
   logic ara_win;
   logic clear_evt;

   assign bus_in = {scl_i, sda_i};
   assign strap_in = {addr_strap_c, addr_strap_b, addr_strap_a};

   sta_strap_dec u_dec (
      .strap(r.strap_s2),
      .addr(dec_addr)
   );

   // ----------------------------------------------------------------
   // bus events
   // ----------------------------------------------------------------
   assign scl_rise = r.bus_s2.scl && !r.bus_q.scl;
   assign scl_fall = !r.bus_s2.scl && r.bus_q.scl;
   assign start_c = r.bus_s2.scl && r.bus_q.scl && r.bus_q.sda && !r.bus_s2.sda;
   assign stop_c = r.bus_s2.scl && r.bus_q.scl && !r.bus_q.sda && r.bus_s2.sda;
   assign pending = |(fault_in & ~r.mask & ~r.auto_mask);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n = r;
      ara_win = 1'b0;
      clear_evt = 1'b0;
      n.bus_s1 = bus_in;
      n.bus_s2 = r.bus_s1;
      n.bus_q = r.bus_s2;
      n.strap_s1 = strap_in;
      n.strap_s2 = r.strap_s1;
      if (!r.addr_ok)
      begin
         if (r.settle == STRAP_SETTLE_CYC)
         begin
            n.addr = dec_addr;
            n.addr_ok = 1'b1;
         end
         else
            n.settle = r.settle + 5'h01;
      end
      if (r.bus_s2.scl)
         n.low_cnt = '0;
      else if (r.low_cnt < TMO_CNT)
         n.low_cnt = r.low_cnt + CNT_W'(1);
      n.stretch_cnt = r.stretch_cnt + CNT_W'(r.scl_drv);
      case (r.st)
         ST_RX:
         begin
            if (scl_rise)
            begin
               n.sh = {r.sh[6:0], r.bus_s2.sda};
               n.bitcnt = r.bitcnt + 4'h1;
            end
            else if (scl_fall && r.bitcnt == BYTE_BITS)
            begin
               n.bitcnt = '0;
               n.st = ST_ACK;
               n.sda_drv = 1'b1;
               case (r.kind)
                  K_ADDR:
                  begin
                     n.ara = 1'b0;
                     n.rd_hi = 1'b0;
                     if (r.addr_ok && r.sh[7:1] == r.addr)
                     begin
                        n.kind = K_CMD;
                        n.more = r.sh[0];
                     end
                     else if (r.addr_ok && r.sh[7:1] == ARA_ADDR && r.sh[0] && pending)
                     begin
                        n.ara = 1'b1;
                        n.more = 1'b1;
                     end
                     else
                     begin
                        n.st = ST_IDLE;
                        n.sda_drv = 1'b0;
                     end
                  end
                  K_CMD:
                  begin
                     n.cmd = r.sh;
                     n.kind = K_DATA;
                     n.wr_hi = 1'b0;
                     clear_evt = (r.sh == CMD_CLEAR_FAULTS);
                  end
                  default:
                  begin
                     if (r.cmd == CMD_ALERT_MASK && r.wr_hi)
                        n.mask[15:8] = r.sh;
                     else if (r.cmd == CMD_ALERT_MASK)
                        n.mask[7:0] = r.sh;
                     n.wr_hi = 1'b1;
                  end
               endcase
            end
         end
         ST_ACK:
         begin
            if (scl_fall)
            begin
               n.sda_drv = 1'b0;
               n.st = ST_RX;
               if (r.more)
               begin
                  n.st = ST_TX;
                  if (r.ara)
                     n.sh = {r.addr, 1'b1};
                  else if (r.cmd == CMD_ALERT_MASK)
                     n.sh = r.mask[7:0];
                  else
                     n.sh = 8'h00;
                  n.sda_drv = !n.sh[7];
               end
            end
         end
         ST_TX:
         begin
            if (scl_rise)
            begin
               if (r.sh[7] && !r.bus_s2.sda)
               begin
                  n.st = ST_IDLE;
                  n.sda_drv = 1'b0;
               end
               else
                  n.bitcnt = r.bitcnt + 4'h1;
            end
            else if (scl_fall)
            begin
               if (r.bitcnt == BYTE_BITS)
               begin
                  n.st = ST_TXACK;
                  n.sda_drv = 1'b0;
                  n.bitcnt = '0;
                  n.more = 1'b0;
                  ara_win = r.ara;
               end
               else
               begin
                  n.sh = {r.sh[6:0], 1'b0};
                  n.sda_drv = !r.sh[6];
               end
            end
         end
         ST_TXACK:
         begin
            if (scl_rise && !r.bus_s2.sda && !r.ara && !r.rd_hi)
            begin
               n.rd_hi = 1'b1;
               n.more = 1'b1;
            end
            else if (scl_fall && r.more)
            begin
               n.st = ST_TX;
               n.more = 1'b0;
               n.sh = (r.cmd == CMD_ALERT_MASK) ? r.mask[15:8] : 8'h00;
               n.sda_drv = !n.sh[7];
            end
            else if (scl_fall)
               n.st = ST_IDLE;
         end
         default:
         begin
         end
      endcase
      if (ara_win)
         n.auto_mask = r.auto_mask | fault_in;
      if (clear_evt)
         n.auto_mask = '0;
      if (start_c)
      begin
         n.st = ST_RX;
         n.kind = K_ADDR;
         n.bitcnt = '0;
         n.sda_drv = 1'b0;
         n.ara = 1'b0;
         n.more = 1'b0;
         n.stretch_cnt = '0;
      end
      if (stop_c)
      begin
         n.st = ST_IDLE;
         n.sda_drv = 1'b0;
         n.stretch_cnt = '0;
      end
      n.scl_drv = (n.st != ST_IDLE) && hold_req && (r.scl_drv || scl_fall)
                  && (n.stretch_cnt < STR_CNT);
      if (n.stretch_cnt >= STR_CNT)
      begin
         n.st = ST_IDLE;
         n.sda_drv = 1'b0;
         n.stretch_cnt = STR_CNT;
      end
      if (r.low_cnt == TMO_CNT)
      begin
         n.st = ST_IDLE;
         n.sda_drv = 1'b0;
         n.scl_drv = 1'b0;
      end
      n.alert_drv = pending;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r <= '0;
         r.bus_s1 <= 2'h3;
         r.bus_s2 <= 2'h3;
         r.bus_q <= 2'h3;
         r.mask <= MASK_RST;
      end
      else
         r <= n;
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign alert_o = 1'b0;
   assign scl_oe_n = !r.scl_drv;
   assign sda_oe_n = !r.sda_drv;
   assign alert_oe_n = !r.alert_drv;
   assign own_addr = r.addr;
   assign own_addr_vld = r.addr_ok;
   assign auto_alert_suppress = r.auto_mask;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   property p_addr_legal;
      r.addr_ok |-> (r.addr >= ADDR_BASE_A && r.addr <= ADDR_LAST_A)
         || (r.addr >= ADDR_BASE_B && r.addr <= ADDR_LAST_B)
         || (r.addr >= ADDR_BASE_C && r.addr <= ADDR_LAST_C);
   endproperty
   a_addr_legal: assert property (p_addr_legal) else $error("illegal own address");

   property p_addr_hold;
      $past(r.addr_ok) |-> r.addr_ok && $stable(r.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");

   property p_tmo;
      (r.low_cnt == TMO_CNT) |=> (r.st == ST_IDLE) && !r.sda_drv && !r.scl_drv;
   endproperty
   a_tmo: assert property (p_tmo) else $error("no reset after clock low timeout");

   property p_str_budget;
      (r.stretch_cnt == STR_CNT) |-> !r.scl_drv && !r.sda_drv && (r.st == ST_IDLE);
   endproperty
   a_str_budget: assert property (p_str_budget) else $error("stretch over budget");

   property p_gate;
      r.alert_drv |-> $past(pending);
   endproperty
   a_gate: assert property (p_gate) else $error("alert driven while masked");

   property p_auto_src;
      (|(r.auto_mask & ~$past(r.auto_mask))) |-> $past(ara_win);
   endproperty
   a_auto_src: assert property (p_auto_src) else $error("automatic mask set without win");

   property p_lost;
      (r.st == ST_TX && scl_rise && r.sh[7] && !r.bus_s2.sda && !stop_c && !start_c)
         |=> (r.st == ST_IDLE) && $stable(r.auto_mask);
   endproperty
   a_lost: assert property (p_lost) else $error("lost arbitration mishandled");

   property p_release;
      ara_win ##1 ($stable(fault_in) && !clear_evt) |=> !r.alert_drv;
   endproperty
   a_release: assert property (p_release) else $error("alert kept after win");

   property p_cover;
      ara_win |=> ((r.auto_mask & $past(fault_in)) == $past(fault_in));
   endproperty
   a_cover: assert property (p_cover) else $error("present fault not masked");

   property p_clear;
      clear_evt |=> (r.auto_mask == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear faults left mask set");

endmodule // sta_target

// ==== sta_host_model.sv ====
module sta_host_model (
   input wire scl,
   input wire sda,
   output logic scl_pd,
   output logic sda_pd
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last_ack;

   initial
   begin
      scl_pd = 1'b0;
      sda_pd = 1'b0;
      last_ack = 1'b1;
   end

   // ----------------------------------------------------------------
   // line sequences, pd high pulls the line low
   // ----------------------------------------------------------------
   // fixed low phase keeps own clock extension far below 10 ms
   task automatic bit_x(input logic b, output logic r);
      sda_pd = ~b;
      #62.5;
      scl_pd = 1'b0;
      wait (scl === 1'b1);
      #31;
      r = sda;
      #31.5;
      scl_pd = 1'b1;
   endtask

   task automatic start();
      sda_pd = 1'b0;
      #62.5;
      scl_pd = 1'b0;
      #62.5;
      sda_pd = 1'b1;
      #62.5;
      scl_pd = 1'b1;
   endtask

   task automatic stop();
      sda_pd = 1'b1;
      #62.5;
      scl_pd = 1'b0;
      #62.5;
      sda_pd = 1'b0;
      #62.5;
   endtask

   // zero bits driven here win arbitration on the wired line
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], r[i]);
      end
      bit_x(ack, last_ack);
   endtask
endmodule // sta_host_model

// ==== test_smbus_target_addr_alert.sv ====
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
      end \
   end

module test_smbus_target_addr_alert;
   timeunit 1ns;
   timeprecision 100ps;
   import sta_pkg::*;
   localparam int TMO = 2000;
   localparam int STR = 500;
   localparam int LIMIT = 60000;
   localparam logic [6:0] ADDR = 7'h40;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   sta_strap_t sa = '0;
   sta_strap_t sb = '0;
   sta_strap_t sc = '0;
   logic [MASK_W-1:0] fault = '0;
   logic [MASK_W-1:0] auto_sup;
   logic hold_req = 1'b0;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, alert_o, alert_oe_n, own_vld, scl_pd, sda_pd, ack;
   logic [6:0] own;
   logic [7:0] r;
   logic [15:0] d;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   wire scl = ~scl_pd & (scl_oe_n | scl_o);
   wire sda = ~sda_pd & (sda_oe_n | sda_o);

   sta_target #(.TMO_CYC(TMO), .STRETCH_CYC(STR)) sta_target_inst (.mclk(mclk),
      .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .addr_strap_a(sa), .addr_strap_b(sb),
      .addr_strap_c(sc), .fault_in(fault), .hold_req(hold_req), .scl_o(scl_o),
      .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o),
      .alert_oe_n(alert_oe_n), .own_addr(own), .own_addr_vld(own_vld),
      .auto_alert_suppress(auto_sup));
   sta_host_model sta_host_model_inst (.scl(scl), .sda(sda), .scl_pd(scl_pd), .sda_pd(sda_pd));

   always #4 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         num_errors++;
         $display("mismatch t=%0t run too long", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic sta_strap_t lv(input int v);
      return (v == 2) ? sta_strap_t'(2'b10) : (v == 1) ? sta_strap_t'(2'b01) : sta_strap_t'(2'b00);
   endfunction

   function automatic logic [6:0] exp_addr(input int i);
      if (i < 8)
         return 7'h40 + 7'(i);
      if (i < 16)
         return 7'h10 + 7'(i - 8);
      return 7'h50 + 7'(i - 16);
   endfunction

   task automatic do_reset(input int i);
      @(negedge mclk);
      sa = lv(i % 3);
      sb = lv((i / 3) % 3);
      sc = lv(i / 9);
      sys_rst = 1'b1;
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK(own_vld, 1'b0);
      repeat (23) @(negedge mclk);
   endtask

   task automatic set_fault(input logic [15:0] v);
      @(negedge mclk);
      fault = v;
      repeat (3) @(negedge mclk);
   endtask

   task automatic wr_cmd(input logic [7:0] c, input int n, input logic [15:0] v);
      sta_host_model_inst.start();
      sta_host_model_inst.xfer({ADDR, 1'b0}, 1'b1, r);
      `CHK(sta_host_model_inst.last_ack, 1'b0);
      sta_host_model_inst.xfer(c, 1'b1, r);
      if (n > 0)
         sta_host_model_inst.xfer(v[7:0], 1'b1, r);
      if (n > 1)
         sta_host_model_inst.xfer(v[15:8], 1'b1, r);
      sta_host_model_inst.stop();
      repeat (5) @(negedge mclk);
   endtask

   task automatic rd16(input logic [7:0] c, output logic [15:0] v);
      sta_host_model_inst.start();
      sta_host_model_inst.xfer({ADDR, 1'b0}, 1'b1, r);
      sta_host_model_inst.xfer(c, 1'b1, r);
      sta_host_model_inst.start();
      sta_host_model_inst.xfer({ADDR, 1'b1}, 1'b1, r);
      sta_host_model_inst.xfer(8'hff, 1'b0, v[7:0]);
      sta_host_model_inst.xfer(8'hff, 1'b1, v[15:8]);
      sta_host_model_inst.stop();
   endtask

   task automatic ara(input logic [7:0] drv, output logic [7:0] got, output logic a);
      sta_host_model_inst.start();
      sta_host_model_inst.xfer({ARA_ADDR, 1'b1}, 1'b1, got);
      a = sta_host_model_inst.last_ack;
      sta_host_model_inst.xfer(drv, 1'b1, got);
      sta_host_model_inst.stop();
      repeat (5) @(negedge mclk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_straps();
      for (int i = 0; i < STRAP_COMBOS; i++)
      begin
         do_reset(i);
         `CHK(own, exp_addr(i));
         `CHK(own_vld, 1'b1);
      end
      do_reset(0);
      sa = lv(2);
      sc = lv(1);
      repeat (40) @(negedge mclk);
      `CHK(own, ADDR);
      // address the new straps would select must stay unanswered
      sta_host_model_inst.start();
      sta_host_model_inst.xfer({7'h13, 1'b0}, 1'b1, r);
      `CHK(sta_host_model_inst.last_ack, 1'b1);
      sta_host_model_inst.stop();
      repeat (5) @(negedge mclk);
      `CHK(auto_sup, 16'h0000);
      `CHK(alert_oe_n, 1'b1);
      `CHK(alert_o, 1'b0);
   endtask

   task automatic t_mask();
      wr_cmd(CMD_ALERT_MASK, 2, 16'hc305);
      rd16(CMD_ALERT_MASK, d);
      `CHK(d, 16'hc305);
      rd16(8'h20, d);
      `CHK(d, 16'h0000);
      set_fault(16'h0001);
      `CHK(alert_oe_n, 1'b1);
      ara(8'hff, r, ack);
      `CHK(ack, 1'b1);
      `CHK(auto_sup, 16'h0000);
      set_fault(16'h0003);
      `CHK(alert_oe_n, 1'b0);
      set_fault(16'h0000);
      wr_cmd(CMD_ALERT_MASK, 2, 16'h0000);
   endtask

   task automatic t_ara_win();
      set_fault(16'h0005);
      `CHK(alert_oe_n, 1'b0);
      ara(8'hff, r, ack);
      `CHK(ack, 1'b0);
      `CHK(r, {ADDR, 1'b1});
      `CHK(auto_sup, 16'h0005);
      `CHK(alert_oe_n, 1'b1);
      set_fault(16'h0004);
      `CHK(alert_oe_n, 1'b1);
      set_fault(16'h0006);
      `CHK(alert_oe_n, 1'b0);
      // host keeps reading while the line is low
      ara(8'hff, r, ack);
      `CHK(auto_sup, 16'h0007);
      `CHK(alert_oe_n, 1'b1);
      wr_cmd(CMD_CLEAR_FAULTS, 0, 16'h0000);
      `CHK(auto_sup, 16'h0000);
      `CHK(alert_oe_n, 1'b0);
      set_fault(16'h0000);
   endtask

   task automatic t_ara_lose();
      set_fault(16'h0010);
      ara(8'h21, r, ack);
      `CHK(r, 8'h21);
      `CHK(auto_sup, 16'h0000);
      `CHK(alert_oe_n, 1'b0);
      set_fault(16'h0000);
   endtask

   task automatic t_timeout();
      logic [7:0] bw;
      bw = {ADDR, 1'b0};
      sta_host_model_inst.start();
      for (int i = 7; i >= 0; i--)
      begin
         sta_host_model_inst.bit_x(bw[i], ack);
      end
      repeat (40) @(negedge mclk);
      `CHK(sda_oe_n, 1'b0);
      repeat (TMO - 60) @(negedge mclk);
      `CHK(sda_oe_n, 1'b0);
      repeat (80) @(negedge mclk);
      `CHK(sda_oe_n, 1'b1);
      sta_host_model_inst.stop();
   endtask

   task automatic t_stretch();
      @(negedge mclk);
      hold_req = 1'b1;
      sta_host_model_inst.start();
      repeat (20) @(negedge mclk);
      `CHK(scl_oe_n, 1'b0);
      repeat (STR - 60) @(negedge mclk);
      `CHK(scl_oe_n, 1'b0);
      repeat (80) @(negedge mclk);
      `CHK(scl_oe_n, 1'b1);
      `CHK(sda_oe_n, 1'b1);
      hold_req = 1'b0;
      sta_host_model_inst.stop();
      wr_cmd(CMD_CLEAR_FAULTS, 0, 16'h0000);
   endtask

   initial
   begin
      t_straps();
      t_mask();
      t_ara_win();
      t_ara_lose();
      t_timeout();
      wr_cmd(CMD_CLEAR_FAULTS, 0, 16'h0000);
      t_stretch();
      tally_and_finish();
   end
endmodule // test_smbus_target_addr_alert
